// file: verilog/csr_map.svh
// register offsets, field positions and reset values of the charger status bytes
// assumes inclusion by the status register bank and its package users
`ifndef CSR_MAP_SVH
`define CSR_MAP_SVH
`define CSR_ADDR_W 8
`define CSR_OFS_LOOP_TEMP 8'h02
`define CSR_OFS_STATE_DETAIL 8'h03
`define CSR_RESET_BYTE 8'h00
`define CSR_BIT_MIN_SYS 4
`define CSR_BIT_DIE_TEMP 3
`define CSR_BIT_CHARGING 1
`define CSR_BIT_TIMER_SUS 0
`define CSR_ZONE_OFF 3'h0
`define CSR_ZONE_COLD 3'h1
`define CSR_ZONE_COOL 3'h2
`define CSR_ZONE_WARM 3'h3
`define CSR_ZONE_HOT 3'h4
`define CSR_ZONE_NORMAL 3'h5
`define CSR_SUPPLY_UVLO 2'h0
`define CSR_SUPPLY_OVP 2'h1
`define CSR_SUPPLY_DEBOUNCE 2'h2
`define CSR_SUPPLY_OK 2'h3
`endif

// file: verilog/csr_pkg.sv
// types shared by the charger status register bank
// assumes csr_map.svh is on the include path
package csr_pkg;
  typedef enum logic [1:0] {
    CSR_SUP_UVLO = 2'b00,
    CSR_SUP_OVP = 2'b01,
    CSR_SUP_DEBOUNCE = 2'b10,
    CSR_SUP_OK = 2'b11
  } csr_supply_t;
  // raw conditions coming from the charger core
  typedef struct packed {
    logic min_system_loop_active;
    logic die_temp_loop_active;
    logic thermistor_enable;
    logic charger_enable;
    logic [2:0] battery_temp_zone;
    logic [3:0] charger_state_detail;
    logic [1:0] input_supply_detail;
    logic charging_active;
    logic cc_mode;
    logic current_below_20pct;
    logic supplement_mode;
  } csr_core_t;
endpackage

// file: verilog/csr_status_bank.sv
// read-only charger status register bank: two status bytes from live core conditions
// assumes core condition inputs are asynchronous to ref_clk and a simple read/write port
`timescale 1ns/10ps
`include "csr_map.svh"
// Operation
// RULE1: status A bit 5 reserved; written as zero, reads ignored; device returns zero.
// RULE2: status A bit 4 is one while minimum system voltage loop engaged.
// RULE3: status A bit 3 is one while die temperature loop engaged.
// RULE4: software trusts the zone field only when supply detail equals 0b11.
// RULE5: zone codes: off, cold, cool, warm, hot, normal; codes six and seven reserved.
// RULE6: thermistor and charger enabled with cold or hot zone raises temperature fault.
// RULE7: supply detail codes: undervoltage, overvoltage, debouncing, valid.
// RULE8: status B bit 1 is one while charging is in progress.
// RULE9: status B bit 0 set on low CC current, supplement mode, or temperature fault.
// RULE10: all fields read-only, live; writes ignored; reserved zone codes never produced.
module csr_status_bank
  import csr_pkg::*;
#(
  // register offset width; the map fits in eight bits
  parameter int ADDR_W = `CSR_ADDR_W
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // register port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // core conditions
  input wire csr_core_t core_in,
  // derived fault
  output logic batt_temp_fault
);
  ////////////////////////////////////////////////////////////////////////////
  // core conditions: two synchroniser stages, one more copy, then a coherent hold
  csr_core_t meta_r;
  csr_core_t sync_r;
  csr_core_t stable_r;
  csr_core_t core_r;
  csr_core_t core_nxt;
  // status bytes, read data and fault level
  logic [7:0] stat_a_r;
  logic [7:0] stat_b_r;
  logic [7:0] rdata_r;
  logic fault_r;
  csr_supply_t supply_w;

  // offsets must fit the address and stay decodable
  if (ADDR_W < 2 || ADDR_W > 16)
  begin : addr_w_check
    $error("register offset width out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // reserved zone inputs are reported as the normal region
  function automatic logic [2:0] zone_clean(input logic [2:0] z);
    zone_clean = (z > `CSR_ZONE_NORMAL) ? `CSR_ZONE_NORMAL : z;
  endfunction

  function automatic logic zone_faults(input logic [2:0] z);
    zone_faults = (z == `CSR_ZONE_COLD) || (z == `CSR_ZONE_HOT);
  endfunction

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    reg_hit = a == ADDR_W'(ofs);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // a word is taken only when two successive samples agree, so a multi-bit
  // code caught mid-change never shows a false zone or a false fault
  wire logic sync_same = sync_r == stable_r;
  assign core_nxt = sync_same ? sync_r : core_r; // [RULE10]

  wire logic [2:0] zone_w = core_r.thermistor_enable ?
    zone_clean(core_r.battery_temp_zone) : `CSR_ZONE_OFF; // [RULE5] [RULE10]
  wire logic fault_nxt = core_r.thermistor_enable && core_r.charger_enable
    && zone_faults(zone_w); // [RULE6]
  wire logic low_cc_w = core_r.cc_mode && core_r.current_below_20pct;
  wire logic sus_nxt = low_cc_w || core_r.supplement_mode || fault_nxt; // [RULE9]
  assign supply_w = csr_supply_t'(core_r.input_supply_detail); // [RULE7]
  wire logic [7:0] stat_a_nxt = {3'h0, core_r.min_system_loop_active,
    core_r.die_temp_loop_active, zone_w}; // [RULE1] [RULE2] [RULE3]
  wire logic [7:0] stat_b_nxt = {core_r.charger_state_detail, supply_w,
    core_r.charging_active, sus_nxt}; // [RULE7] [RULE8]

  ////////////////////////////////////////////////////////////////////////////
  // writes have no effect on any field
  wire logic sel_a = reg_hit(addr, `CSR_OFS_LOOP_TEMP);
  wire logic sel_b = reg_hit(addr, `CSR_OFS_STATE_DETAIL);
  wire logic [7:0] read_mux = sel_a ? stat_a_r : sel_b ? stat_b_r : 8'h00;
  wire logic [7:0] rdata_nxt = rd_en ? read_mux : rdata_r; // [RULE10]

  ////////////////////////////////////////////////////////////////////////////
  // synchroniser: only sync_r reads meta_r
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= core_in;
      sync_r <= meta_r;
    end
  end

  // coherent hold stage
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stable_r <= '0;
      core_r <= '0;
    end
    else
    begin
      stable_r <= sync_r;
      core_r <= core_nxt;
    end
  end

  // status bytes follow the held word every cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stat_a_r <= `CSR_RESET_BYTE;
      stat_b_r <= `CSR_RESET_BYTE;
    end
    else
    begin
      stat_a_r <= stat_a_nxt;
      stat_b_r <= stat_b_nxt;
    end
  end

  // read data stands until the next read
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_r <= `CSR_RESET_BYTE;
      fault_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      fault_r <= fault_nxt;
    end
  end

  assign rdata = rdata_r;
  assign batt_temp_fault = fault_r;

  ////////////////////////////////////////////////////////////////////////////
  rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE1]
    stat_a_r[7:5] == 3'h0) else $error("reserved status bits not zero");
  min_sys_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
    core_r.min_system_loop_active |=> stat_a_r[`CSR_BIT_MIN_SYS])
    else $error("min system bit not set");
  min_sys_track_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE2]
    ##1 stat_a_r[`CSR_BIT_MIN_SYS] == $past(core_r.min_system_loop_active))
    else $error("min system bit does not track loop");
  die_temp_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE3]
    $rose(core_r.die_temp_loop_active) |=> stat_a_r[`CSR_BIT_DIE_TEMP])
    else $error("die temp bit not set");
  zone_legal_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    stat_a_r[2:0] <= `CSR_ZONE_NORMAL) else $error("reserved zone code produced");
  zone_off_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE5]
    !core_r.thermistor_enable |=> stat_a_r[2:0] == `CSR_ZONE_OFF)
    else $error("zone not off with thermistor disabled");
  fault_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
    fault_nxt |=> batt_temp_fault && stat_b_r[`CSR_BIT_TIMER_SUS])
    else $error("fault not flagged or timer not suspended");
  fault_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
    !fault_nxt |=> !batt_temp_fault)
    else $error("fault flagged without its condition");
  fault_zone_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE6]
    batt_temp_fault |-> $past(zone_faults(zone_w)))
    else $error("fault flagged outside cold or hot zone");
  charging_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE8]
    core_r.charging_active |=> stat_b_r[`CSR_BIT_CHARGING])
    else $error("charging bit not set");
  charging_clear_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE8]
    !core_r.charging_active |=> !stat_b_r[`CSR_BIT_CHARGING])
    else $error("charging bit set while idle");
  supply_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE7]
    ##1 stat_b_r[3:2] == $past(core_r.input_supply_detail))
    else $error("supply detail mismatch");
  sus_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
    (core_r.cc_mode && core_r.current_below_20pct) |=> stat_b_r[`CSR_BIT_TIMER_SUS])
    else $error("timer not suspended on low current");
  sus_supp_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE9]
    core_r.supplement_mode |=> stat_b_r[`CSR_BIT_TIMER_SUS])
    else $error("timer not suspended in supplement mode");
  detail_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    ##1 stat_b_r[7:4] == $past(core_r.charger_state_detail))
    else $error("state detail does not track core");
  coherent_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    !sync_same |=> core_r == $past(core_r))
    else $error("core word taken while changing");
  read_a_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    rd_en && sel_a |=> rdata == $past(stat_a_r))
    else $error("status a read mismatch");
  read_b_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    rd_en && sel_b |=> rdata == $past(stat_b_r))
    else $error("status b read mismatch");
  unmapped_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    rd_en && !sel_a && !sel_b |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  write_a: assert property (@(posedge ref_clk) disable iff (reset) // [RULE10]
    wr_en && !rd_en |=> rdata == $past(rdata)) else $error("write disturbed read data");

  // main scenarios
  cov_fault_c: cover property (@(posedge ref_clk) disable iff (reset) batt_temp_fault);
  cov_read_a_c: cover property (@(posedge ref_clk) disable iff (reset) rd_en && sel_a);
  cov_read_b_c: cover property (@(posedge ref_clk) disable iff (reset) rd_en && sel_b);
  cov_supp_c: cover property (@(posedge ref_clk) disable iff (reset)
    core_r.supplement_mode ##1 stat_b_r[0]);
  cov_supply_ok_c: cover property (@(posedge ref_clk) disable iff (reset)
    supply_w == CSR_SUP_OK);
endmodule

// file: tb/test_csr_status_bank.sv
// self-checking bench for the charger status register bank
// assumes csr_pkg and csr_map.svh are compiled ahead of it
`timescale 1ns/10ps
module test_csr_status_bank;
  import csr_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic batt_temp_fault;
  csr_core_t core_in = '0;
  csr_core_t c = '0;
  int errors = 0;
  int cmp_count = 0;
  int i;
  logic [7:0] exp_a = 8'h00;
  logic [7:0] exp_b = 8'h00;
  csr_status_bank csr_status_bank_i (.ref_clk(ref_clk), .reset(reset), .rd_en(rd_en),
    .wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata), .core_in(core_in),
    .batt_temp_fault(batt_temp_fault));
  initial
  begin
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge ref_clk);
    rd_en = 1'b0;
    v = rdata;
  endtask
  // write a byte, then read the same offset back in the next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, output logic [7:0] v);
    @(negedge ref_clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge ref_clk);
    wr_en = 1'b0;
    rd_en = 1'b1;
    @(negedge ref_clk);
    rd_en = 1'b0;
    v = rdata;
  endtask
  // apply conditions, let the sync settle, then judge both bytes and the fault
  task automatic check_all;
    logic [2:0] z;
    logic f;
    logic [7:0] v;
    z = !c.thermistor_enable ? 3'h0 :
      (c.battery_temp_zone > 3'h5 ? 3'h5 : c.battery_temp_zone);
    f = c.thermistor_enable && c.charger_enable && (z == 3'h1 || z == 3'h4);
    exp_a = {3'h0, c.min_system_loop_active, c.die_temp_loop_active, z};
    exp_b = {c.charger_state_detail, c.input_supply_detail, c.charging_active,
      (c.cc_mode && c.current_below_20pct) || c.supplement_mode || f};
    core_in = c;
    repeat (6) @(negedge ref_clk);
    chk({7'h00, batt_temp_fault}, {7'h00, f}); // fault level
    rd(8'h02, v);
    chk(v, exp_a); // a
    rd(8'h03, v);
    chk(v, exp_b); // b
  endtask
  task automatic zone_sweep;
    c = '0;
    c.thermistor_enable = 1'b1;
    c.charger_enable = 1'b1;
    c.input_supply_detail = 2'h3; // zone read only with supply valid
    for (i = 0; i < 8; i++)
    begin
      c.battery_temp_zone = i[2:0];
      check_all();
    end
    c.thermistor_enable = 1'b0;
    c.battery_temp_zone = 3'h1;
    check_all();
    c.thermistor_enable = 1'b1;
    c.charger_enable = 1'b0;
    c.battery_temp_zone = 3'h4;
    check_all();
  endtask
  task automatic flag_cases;
    logic [7:0] v;
    c = '0;
    for (i = 0; i < 4; i++)
    begin
      c.input_supply_detail = i[1:0];
      c.charger_state_detail = {i[1:0], ~i[1:0]};
      c.min_system_loop_active = i[0];
      c.die_temp_loop_active = ~i[0];
      c.charging_active = i[1];
      c.cc_mode = i[0];
      c.current_below_20pct = i[1];
      c.supplement_mode = (i == 2);
      check_all();
    end
    wr_rd(8'h03, 8'hff, v);
    chk(v, exp_b); // write to status b ignored
    wr_rd(8'h02, 8'hdf, v);
    chk(v, exp_a); // reserved bit written as zero, write ignored
    check_all();
    rd(8'h04, v);
    chk(v, 8'h00); // unmapped reads zero
  endtask
  task automatic end_sim;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    zone_sweep();
    flag_cases();
    end_sim();
  end
endmodule
